// ===== bus_cond_flags.v
/*
 Start and stop condition flags of a two-wire bus unit, with a small
 register port and a level interrupt. Assumes the bus lines are
 sampled by the 50 MHz system clock, far faster than the bus clock,
 and that software uses the strobed port one access per cycle.
*/
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "bus_flags_map.vh"
module bus_cond_flags
(
    // Clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rst,
    // Register port
    input  wire [3:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    // Two-wire bus lines, listened to only
    input  wire       i_scl,
    input  wire       i_sda,
    // Flags and interrupt
    output wire       o_start_seen_flag,
    output wire       o_stop_seen_flag,
    output wire       o_irq
);

    // Synchronised lines
    wire scl;
    wire scl_rise;
    wire scl_fall;
    wire sda;
    wire sda_rise;
    wire sda_fall;

    // Control register reset image, so single bits can be picked from it
    localparam [7:0] CTL_RESET = `RST_CONTROL;

    // Control state
    reg        bus_unit_enable;
    reg        stop_irq_enable;
    reg        en_last;
    reg        start_seen_flag;
    reg        stop_seen_flag;
    reg        addr_phase;
    reg  [3:0] bit_cnt;
    reg        busy;
    reg  [`EV_WIDTH-1:0] irq_status;
    reg  [`EV_WIDTH-1:0] irq_enable;
    reg  [`EV_WIDTH-1:0] next_irq_status;

    // Decoded accesses and bus conditions
    wire wr_ctl;
    wire release_req;
    wire disable_edge;
    wire start_cond;
    wire stop_cond;
    wire first_clk;
    wire byte_end;
    wire [`EV_WIDTH-1:0] events;
    wire [`EV_WIDTH-1:0] clr_mask;

    line_sync u_scl_sync
    (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_line    (i_scl),
        .o_level   (scl),
        .o_rise    (scl_rise),
        .o_fall    (scl_fall)
    );

    line_sync u_sda_sync
    (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_line    (i_sda),
        .o_level   (sda),
        .o_rise    (sda_rise),
        .o_fall    (sda_fall)
    );

    // Conditions only count while the unit is enabled
    assign start_cond   = bus_unit_enable & scl & sda_fall;
    assign stop_cond    = bus_unit_enable & scl & sda_rise;
    assign wr_ctl       = i_wr & (i_addr == `ADDR_CONTROL);
    assign release_req  = wr_ctl & i_wdata[`CTL_RELEASE_BIT];
    assign disable_edge = en_last & ~bus_unit_enable;
    // First clock of a byte; bit counter at zero after start or acknowledge
    assign first_clk    = bus_unit_enable & busy & scl_rise & (bit_cnt == 4'h0);
    assign byte_end     = bus_unit_enable & busy & scl_fall & (bit_cnt == `BYTE_CLOCKS);

    // Control register: enable and stop interrupt enable
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bus_unit_enable <= CTL_RESET[`CTL_ENABLE_BIT];
            stop_irq_enable <= CTL_RESET[`CTL_STOP_IE_BIT];
            en_last         <= 1'b0;
        end
        else
        begin
            en_last <= bus_unit_enable;
            if (wr_ctl)
            begin
                bus_unit_enable <= i_wdata[`CTL_ENABLE_BIT];
                stop_irq_enable <= i_wdata[`CTL_STOP_IE_BIT];
            end
        end
    end

    // Byte framing: count clocks of each nine-clock byte
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bit_cnt    <= 4'h0;
            busy       <= 1'b0;
            addr_phase <= 1'b0;
        end
        else if (!bus_unit_enable || stop_cond || release_req)
        begin
            // Release drops out of framing until the next start
            bit_cnt    <= 4'h0;
            busy       <= 1'b0;
            addr_phase <= 1'b0;
        end
        else if (start_cond)
        begin
            // RULE2: address period opens
            bit_cnt    <= 4'h0;
            busy       <= 1'b1;
            addr_phase <= 1'b1;
        end
        else if (busy)
        begin
            if (scl_rise)
                bit_cnt <= bit_cnt + 4'h1;
            else if (byte_end)
            begin
                bit_cnt    <= 4'h0;
                addr_phase <= 1'b0;
            end
        end
    end

    // Start-seen flag
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            start_seen_flag <= 1'b0;
        // RULE6: disable clears flag
        else if (disable_edge || !bus_unit_enable)
            start_seen_flag <= 1'b0;
        // RULE1: start sets flag, wins over clears
        else if (start_cond)
            start_seen_flag <= 1'b1;
        // RULE3: stop clears flag
        else if (stop_cond)
            start_seen_flag <= 1'b0;
        // RULE5: release request clears flag
        else if (release_req)
            start_seen_flag <= 1'b0;
        // RULE4: first clock of data byte clears
        else if (first_clk && !addr_phase)
            start_seen_flag <= 1'b0;
    end

    // Stop-seen flag
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            stop_seen_flag <= 1'b0;
        // RULE6: disable clears flag
        else if (disable_edge || !bus_unit_enable)
            stop_seen_flag <= 1'b0;
        // RULE7: stop sets flag
        else if (stop_cond)
            stop_seen_flag <= 1'b1;
        // RULE9: cleared at first address clock
        else if (first_clk && addr_phase)
            stop_seen_flag <= 1'b0;
    end

    // Event sources; stop event only when enabled
    // RULE10: stop interrupt gated
    assign events   = {byte_end, stop_cond & stop_irq_enable, start_cond};
    assign clr_mask = (i_wr && i_addr == `ADDR_IRQ_CLEAR) ? i_wdata[`EV_WIDTH-1:0] : `RST_EVENTS;

    // Sticky status; a set in the clear cycle wins
    always @*
    begin
        next_irq_status = (irq_status & ~clr_mask) | events;
    end

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            irq_status <= `RST_EVENTS;
            irq_enable <= `RST_EVENTS;
        end
        else
        begin
            irq_status <= next_irq_status;
            if (i_wr && i_addr == `ADDR_IRQ_ENABLE)
                irq_enable <= i_wdata[`EV_WIDTH-1:0];
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (!i_rd)
            o_rdata <= 8'h00;
        else if (i_addr == `ADDR_STATUS)
            // RULE8: stop-seen shows bus released
            o_rdata <= {4'h0, busy, addr_phase & start_seen_flag, start_seen_flag, stop_seen_flag};
        else if (i_addr == `ADDR_CONTROL)
            o_rdata <= {bus_unit_enable, 5'h00, stop_irq_enable, 1'b0};
        else if (i_addr == `ADDR_IRQ_STATUS)
            o_rdata <= {5'h00, irq_status};
        else if (i_addr == `ADDR_IRQ_ENABLE)
            o_rdata <= {5'h00, irq_enable};
        else
            o_rdata <= 8'h00;
    end

    // Outputs
    assign o_start_seen_flag = start_seen_flag;
    assign o_stop_seen_flag  = stop_seen_flag;
    assign o_irq             = |(irq_status & irq_enable);

endmodule

// ===== bus_cond_flags_monitor.sv
/* Port assertions for the bus condition flag block.
 Assumes bus lines idle high and far slower than i_sys_clk. */
`timescale 1ns/100ps
module bus_cond_flags_monitor
(
    // Clock, reset, register port
    input wire       i_sys_clk,
    input wire       i_rst,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    // Bus lines and flags
    input wire       i_scl,
    input wire       i_sda,
    input wire       o_start_seen_flag,
    input wire       o_stop_seen_flag,
    input wire       o_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    reg  en;
    wire ctl_wr = i_wr && i_addr == 4'h1;
    // Shadow of the unit enable, so conditions on a disabled unit are not judged
    always @(posedge i_sys_clk or posedge i_rst)
        if (i_rst)
            en <= 1'b0;
        else if (ctl_wr)
            en <= i_wdata[7];
    a_start_sets: assert property ($fell(i_sda) && i_scl && en |-> ##[1:4] o_start_seen_flag)
        else $error("start flag late");
    a_start_cause: assert property ($rose(o_start_seen_flag) |-> $past(i_scl, 2) && !$past(i_sda, 2))
        else $error("start flag without cause");
    a_stop_sets: assert property ($rose(i_sda) && i_scl && en |-> ##[1:4] o_stop_seen_flag)
        else $error("stop flag late");
    a_stop_cause: assert property ($rose(o_stop_seen_flag) |-> $past(i_scl, 2) && $past(i_sda, 2))
        else $error("stop flag without cause");
    a_stop_ends_start: assert property ($rose(i_sda) && i_scl && en |-> ##4 !o_start_seen_flag)
        else $error("start flag kept past stop");
    a_addr_first_clk: assert property (o_start_seen_flag && o_stop_seen_flag && $rose(i_scl)
        |-> ##4 (o_start_seen_flag && !o_stop_seen_flag))
        else $error("first address clock");
    a_off_clears: assert property (!en |=> !o_start_seen_flag && !o_stop_seen_flag)
        else $error("flag set while disabled");
    a_release_clr: assert property (ctl_wr && i_wdata == 8'h81 && en |-> ##[1:2] !o_start_seen_flag)
        else $error("release kept start flag");
    c_restart: cover property (o_start_seen_flag && o_stop_seen_flag);
    c_irq: cover property ($rose(o_irq));
    c_release: cover property (ctl_wr && i_wdata[0]);
endmodule
bind bus_cond_flags bus_cond_flags_monitor mon (.*);

// ===== bus_cond_flags_tb_top.sv
/* Self-checking bench for the bus condition flags.
 Assumes the master model and the bound monitor. */
`timescale 1ns/100ps
module bus_cond_flags_tb_top;
    reg        i_sys_clk = 1'b0;
    reg        i_rst = 1'b1;
    reg  [3:0] i_addr = 4'h0;
    reg  [7:0] i_wdata = 8'h00;
    reg        i_wr = 1'b0;
    reg        i_rd = 1'b0;
    wire [7:0] o_rdata;
    wire       i_scl;
    wire       i_sda;
    wire       o_start_seen_flag;
    wire       o_stop_seen_flag;
    wire       o_irq;
    integer    fail_count = 0;
    integer    comparisons = 0;
    always #10 i_sys_clk = ~i_sys_clk;
    bus_master_model bus (.o_scl(i_scl), .o_sda(i_sda));
    bus_cond_flags dut (.*);
    task check(input [7:0] got, input [7:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    end
    endtask
    // Settle past the edge, then compare start and stop flags
    task fl(input [1:0] e);
    begin
        #1;
        check({6'h00, o_start_seen_flag, o_stop_seen_flag}, {6'h00, e});
    end
    endtask
    task wr(input [3:0] a, input [7:0] d);
    begin
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        #1;
    end
    endtask
    task rd(input [3:0] a, input [7:0] e);
    begin
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, e);
    end
    endtask
    task t_frame;
    begin
        wr(4'h1, 8'h80);
        bus.start_cond;
        fl(2'b10);
        rd(4'h0, 8'h0e);
        bus.send_byte(8'ha4);
        fl(2'b10);
        rd(4'h0, 8'h0a);
        bus.clk_bit(1'b0);
        fl(2'b00);
        bus.stop_cond;
        fl(2'b01);
        rd(4'h0, 8'h01);
        bus.start_cond;
        fl(2'b11);
        bus.clk_bit(1'b1);
        fl(2'b10);
        bus.stop_cond;
        fl(2'b01);
    end
    endtask
    task t_release_off;
    begin
        bus.start_cond;
        wr(4'h1, 8'h81);
        fl(2'b01);
        rd(4'h1, 8'h80);
        bus.start_cond;
        wr(4'h1, 8'h00);
        @(posedge i_sys_clk);
        fl(2'b00);
        bus.stop_cond;
        fl(2'b00);
    end
    endtask
    // Stop irq source off, then on; start bit set but masked
    task t_irq;
    begin
        wr(4'h4, 8'h07);
        wr(4'h3, 8'h02);
        rd(4'h3, 8'h02);
        wr(4'h1, 8'h80);
        bus.start_cond;
        bus.stop_cond;
        rd(4'h2, 8'h01);
        check({7'h00, o_irq}, 8'h00);
        wr(4'h1, 8'h82);
        bus.start_cond;
        bus.stop_cond;
        rd(4'h2, 8'h03);
        check({7'h00, o_irq}, 8'h01);
        wr(4'h4, 8'h02);
        check({7'h00, o_irq}, 8'h00);
    end
    endtask
    task finish_test;
    begin
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'hf, 8'h00);
        t_frame;
        t_release_off;
        t_irq;
        finish_test;
    end
    // Hang guard, well past the few frames above
    initial
    begin
        #200000;
        fail_count = fail_count + 1;
        finish_test;
    end
endmodule

// ===== bus_flags_map.vh
/*
 Register offsets, field positions and reset values for the two-wire
 bus condition flag block. Assumes a plain strobed register port with
 8-bit data and read data returned one cycle after the read strobe.
*/
// Notes on behaviour
// RULE1: Start condition sets start-seen flag
// RULE2: Start-seen high marks address transfer period
// RULE3: Stop condition clears start-seen flag
// RULE4: First clock after address byte clears start-seen
// RULE5: Release request write clears start-seen flag
// RULE6: Disable edge or reset clears both flags
// RULE7: Stop condition sets stop-seen flag
// RULE8: Stop-seen high means bus is released
// RULE9: Stop-seen clears at next address first clock
// RULE10: Stop interrupt only when stop enable set
`ifndef BUS_FLAGS_MAP_VH
`define BUS_FLAGS_MAP_VH

// Register offsets
`define ADDR_STATUS      4'h0
`define ADDR_CONTROL     4'h1
`define ADDR_IRQ_STATUS  4'h2
`define ADDR_IRQ_ENABLE  4'h3
`define ADDR_IRQ_CLEAR   4'h4

// Status register fields
`define STAT_STOP_BIT    0
`define STAT_START_BIT   1
`define STAT_ADDR_BIT    2
`define STAT_BUSY_BIT    3

// Control register fields
`define CTL_RELEASE_BIT  0
`define CTL_STOP_IE_BIT  1
`define CTL_ENABLE_BIT   7

// Event bits of the interrupt registers
`define EV_START_BIT     0
`define EV_STOP_BIT      1
`define EV_BYTE_BIT      2
`define EV_WIDTH         3

// Reset values
`define RST_CONTROL      8'h00
`define RST_EVENTS       3'h0

// Bits per byte including acknowledge clock
`define BYTE_CLOCKS      4'h9

`endif

// ===== bus_master_model.sv
/* Two-wire bus master model for the listened lines.
 Assumes pull-ups, so lines idle high; bus clock period 160 ns. */
`timescale 1ns/100ps
module bus_master_model
(
    // Bus lines
    output reg o_scl,
    output reg o_sda
);
    integer n;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Start, also works as a repeated start from a low clock
    task start_cond;
    begin
        o_sda = 1'b1;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b0;
        #80 o_scl = 1'b0;
    end
    endtask
    task stop_cond;
    begin
        o_sda = 1'b0;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b1;
        #80;
    end
    endtask
    // Data only changes while the clock is low
    task clk_bit(input b);
    begin
        o_sda = b;
        #40 o_scl = 1'b1;
        #80 o_scl = 1'b0;
        #40;
    end
    endtask
    // Eight bits then a released acknowledge
    task send_byte(input [7:0] d);
    begin
        for (n = 7; n >= 0; n = n - 1)
            clk_bit(d[n]);
        clk_bit(1'b1);
    end
    endtask
endmodule

// ===== line_sync.v
/*
 Two-flop synchroniser with edge detection for one bus line.
 Assumes the input is asynchronous to i_sys_clk and changes slowly
 compared with it.
*/
`timescale 1ns/100ps
module line_sync
(
    // Clock and reset
    input  wire i_sys_clk,
    input  wire i_rst,
    // Raw line
    input  wire i_line,
    // Synchronised line and edges
    output reg  o_level,
    output wire o_rise,
    output wire o_fall
);

    reg meta;
    reg last;

    // Two stages, then a delayed copy for edges; the first flop feeds only the second
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta    <= 1'b1;
            o_level <= 1'b1;
            last    <= 1'b1;
        end
        else
        begin
            meta    <= i_line;
            o_level <= meta;
            last    <= o_level;
        end
    end

    // Edges seen on the synchronised level
    assign o_rise = o_level & ~last;
    assign o_fall = ~o_level & last;

endmodule
